// *** logic/srg_pkg.sv ***
// How it works
// - Burst mode emits exactly N pulses, N from 1 to 15; zero reserved.
// - Burst counter gates divider output; pulses keep divider duty and rate.
// - Divider divides pre-divided clock by N, 2 to 4095; 0 and 1 reserved.
// - Mode 0 continuous, 1 counted burst, 2 repeat request, 3 reserved.
// - Phase select 0 inverted I, 1 inverted Q, 2 Q, 3 I clock.
// - Reset gives count one, divider three, continuous, I 0x7F, rest zero.
// - Pre-divider 0 divides by one, 1 by two, 2 by four; 3 reserved.
// - Subsystem enable low disables generation, divider and delay path.
package srg_pkg;
	localparam logic [7:0] OFS_BURST_DIV = 8'h10;
	localparam logic [7:0] OFS_MODE_OUT0 = 8'h11;
	localparam logic [7:0] OFS_OUT1_Q0 = 8'h12;
	localparam logic [7:0] OFS_OUT2_Q1 = 8'h13;
	localparam logic [7:0] OFS_CTRL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h41;
	localparam logic [15:0] RST_BURST_DIV = 16'h1003;
	localparam logic [15:0] RST_MODE_OUT0 = 16'h07F0;
	localparam logic [15:0] RST_OUT_Q = 16'hFE00;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [15:0] MODE_OUT0_MASK = 16'h07FF;
	localparam logic [15:0] CTRL_MASK = 16'h0013;
	localparam int COUNT_LSB = 12;
	localparam int DIV_LSB = 0;
	localparam int WI_LSB = 9;
	localparam int PH_LSB = 7;
	localparam int WQ_LSB = 0;
	localparam int W0I_LSB = 4;
	localparam int PH0_LSB = 2;
	localparam int MODE_LSB = 0;
	localparam int EN_BIT = 4;
	localparam int PRE_LSB = 0;
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_BURST = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h2;
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV2 = 2'h1;
	localparam logic [1:0] PRE_DIV4 = 2'h2;
	localparam logic [1:0] PH_INTERP_INPHASE_CLOCK_N = 2'h0;
	localparam logic [1:0] PH_INTERP_QUADRATURE_CLOCK_N = 2'h1;
	localparam logic [1:0] PH_INTERP_QUADRATURE_CLOCK = 2'h2;
	localparam logic [1:0] PH_INTERP_INPHASE_CLOCK = 2'h3;
	localparam logic [6:0] WEIGHT_SUM = 7'h7F;
	typedef enum logic [1:0] {SRG_IDLE, SRG_RUN, SRG_BURST} srg_state_e;
endpackage : srg_pkg

// *** logic/srg_divider.sv ***
`timescale 1ns/1ps
// Pre-divider plus reference-pulse divider; high for floor(N/2) of N ticks
module srg_divider import srg_pkg::*; #(
	parameter int DIV_W = 12
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic [1:0] pre_sel,
	input wire logic [DIV_W-1:0] ratio,
	output logic div_out,
	output logic period_end
);
	logic [1:0] pre_cnt;
	logic [1:0] next_pre_cnt;
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] next_cnt;
	logic tick;
	logic [DIV_W-1:0] eff_ratio;

	// Pre-divide tick and main count; reserved ratios clamp to two
	always_comb begin
		next_pre_cnt = pre_cnt + 2'h1;
		case (pre_sel)
			PRE_DIV1: tick = 1'b1;
			PRE_DIV2: tick = pre_cnt[0];
			PRE_DIV4: tick = &pre_cnt;
			default: tick = 1'b1;
		endcase
		eff_ratio = (ratio < DIV_W'(2)) ? DIV_W'(2) : ratio;
		next_cnt = cnt;
		if (tick) begin
			next_cnt = (cnt >= eff_ratio - DIV_W'(1)) ? '0 : cnt + DIV_W'(1);
		end
		if (!enable) begin
			next_pre_cnt = 2'h0;
			next_cnt = '0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_cnt <= 2'h0;
			cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
			cnt <= next_cnt;
		end
	end

	// Output decode; odd ratios lose 50% duty, which software must tolerate
	assign div_out = enable && (cnt < (eff_ratio >> 1));
	assign period_end = enable && tick && (cnt >= eff_ratio - DIV_W'(1));
endmodule : srg_divider

// *** logic/srg_top.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module srg_top import srg_pkg::*; #(
	parameter int DIV_W = 12,
	parameter int CNT_W = 4
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic burst_req,
	input wire logic ext_req,
	input wire logic interp_inphase_clock,
	input wire logic interp_quadrature_clock,
	output logic [2:0] ref_pulse_out,
	output logic [2:0] retimer_clk_out,
	output logic [20:0] delay_weights,
	output logic delay_gen_bypass
);
	logic [15:0] reg_burst_div;
	logic [15:0] reg_mode_out0;
	logic [15:0] reg_out1_q0;
	logic [15:0] reg_out2_q1;
	logic [15:0] reg_ctrl;
	logic [15:0] next_burst_div;
	logic [15:0] next_mode_out0;
	logic [15:0] next_out1_q0;
	logic [15:0] next_out2_q1;
	logic [15:0] next_ctrl;
	logic [15:0] next_rdata;
	srg_state_e state;
	srg_state_e next_state;
	logic [CNT_W-1:0] left;
	logic [CNT_W-1:0] next_left;
	logic [2:0] next_pulse;
	logic [2:0] next_rt;
	logic [20:0] next_w;
	logic div_out;
	logic period_end;
	logic gate;
	logic ref_pulse_subsystem_enable;
	logic [1:0] ref_pulse_source_mode;
	logic [1:0] ref_pulse_predivider;
	logic [CNT_W-1:0] burst_pulse_count;
	logic [DIV_W-1:0] ref_pulse_divider;
	logic [1:0] phase_sel [3];
	logic [6:0] inphase_w [3];
	logic [CNT_W-1:0] burst_load;

	assign burst_pulse_count = reg_burst_div[COUNT_LSB +: CNT_W];
	assign ref_pulse_divider = reg_burst_div[DIV_LSB +: DIV_W];
	assign ref_pulse_source_mode = reg_mode_out0[MODE_LSB +: 2];
	assign ref_pulse_subsystem_enable = reg_ctrl[EN_BIT];
	assign ref_pulse_predivider = reg_ctrl[PRE_LSB +: 2];
	assign phase_sel[0] = reg_mode_out0[PH0_LSB +: 2];
	assign phase_sel[1] = reg_out1_q0[PH_LSB +: 2];
	assign phase_sel[2] = reg_out2_q1[PH_LSB +: 2];
	assign inphase_w[0] = reg_mode_out0[W0I_LSB +: 7];
	assign inphase_w[1] = reg_out1_q0[WI_LSB +: 7];
	assign inphase_w[2] = reg_out2_q1[WI_LSB +: 7];
	// Reserved count zero is run as a single pulse
	assign burst_load = (burst_pulse_count == '0) ? CNT_W'(1) : burst_pulse_count;

	// Retimer clock pick, shared by all three outputs
	function automatic logic pick_clk(input logic [1:0] sel, input logic ic, input logic qc);
		case (sel)
			PH_INTERP_INPHASE_CLOCK_N: pick_clk = ~ic;
			PH_INTERP_QUADRATURE_CLOCK_N: pick_clk = ~qc;
			PH_INTERP_QUADRATURE_CLOCK: pick_clk = qc;
			default: pick_clk = ic;
		endcase
	endfunction : pick_clk

	srg_divider #(
		.DIV_W(DIV_W)
	) u_div (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.enable(ref_pulse_subsystem_enable),
		.pre_sel(ref_pulse_predivider),
		.ratio(ref_pulse_divider),
		.div_out(div_out),
		.period_end(period_end)
	);

	// Register writes and one-cycle-late read data; unmapped reads give zero
	always_comb begin
		next_burst_div = reg_burst_div;
		next_mode_out0 = reg_mode_out0;
		next_out1_q0 = reg_out1_q0;
		next_out2_q1 = reg_out2_q1;
		next_ctrl = reg_ctrl;
		next_rdata = 16'h0000;
		if (wr) begin
			case (addr)
				OFS_BURST_DIV: next_burst_div = wdata;
				OFS_MODE_OUT0: next_mode_out0 = wdata & MODE_OUT0_MASK;
				OFS_OUT1_Q0: next_out1_q0 = wdata;
				OFS_OUT2_Q1: next_out2_q1 = wdata;
				OFS_CTRL: next_ctrl = wdata & CTRL_MASK;
				default: next_ctrl = reg_ctrl;
			endcase
		end
		if (rd) begin
			case (addr)
				OFS_BURST_DIV: next_rdata = reg_burst_div;
				OFS_MODE_OUT0: next_rdata = reg_mode_out0;
				OFS_OUT1_Q0: next_rdata = reg_out1_q0;
				OFS_OUT2_Q1: next_rdata = reg_out2_q1;
				OFS_CTRL: next_rdata = reg_ctrl;
				OFS_STATUS: next_rdata = {10'h000, state != SRG_IDLE, left, div_out};
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_burst_div <= RST_BURST_DIV;
			reg_mode_out0 <= RST_MODE_OUT0;
			reg_out1_q0 <= RST_OUT_Q;
			reg_out2_q1 <= RST_OUT_Q;
			reg_ctrl <= RST_CTRL;
			rdata <= 16'h0000;
		end else begin
			reg_burst_div <= next_burst_div;
			reg_mode_out0 <= next_mode_out0;
			reg_out1_q0 <= next_out1_q0;
			reg_out2_q1 <= next_out2_q1;
			reg_ctrl <= next_ctrl;
			rdata <= next_rdata;
		end
	end

	// Burst sequencer: arm on request, wait for a period end, then count periods.
	// The wait keeps the first pulse whole, as a request never restarts the divider; only enable low clears it.
	always_comb begin
		next_state = state;
		next_left = left;
		case (state)
			SRG_IDLE: begin
				if (ref_pulse_source_mode == MODE_BURST && burst_req) begin
					next_state = SRG_RUN;
					next_left = burst_load;
				end
			end
			SRG_RUN: begin
				if (burst_req) begin
					next_left = burst_load;
				end else if (period_end) begin
					next_state = SRG_BURST;
				end
				if (ref_pulse_source_mode != MODE_BURST) begin
					next_state = SRG_IDLE;
				end
			end
			SRG_BURST: begin
				if (burst_req) begin
					next_state = SRG_RUN;
					next_left = burst_load;
				end else if (period_end) begin
					next_left = left - CNT_W'(1);
					if (left == CNT_W'(1)) begin
						next_state = SRG_IDLE;
					end
				end
				if (ref_pulse_source_mode != MODE_BURST) begin
					next_state = SRG_IDLE;
				end
			end
			default: next_state = SRG_IDLE;
		endcase
		if (!ref_pulse_subsystem_enable) begin
			next_state = SRG_IDLE;
			next_left = '0;
		end
		if (next_state == SRG_IDLE) begin
			next_left = '0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SRG_IDLE;
			left <= '0;
		end else begin
			state <= next_state;
			left <= next_left;
		end
	end

	// Gate source by mode; burst starts only from a period boundary, cnt=0
	always_comb begin
		case (ref_pulse_source_mode)
			MODE_CONT: gate = div_out;
			MODE_BURST: gate = div_out && state == SRG_BURST;
			MODE_REPEAT: gate = ext_req;
			default: gate = 1'b0;
		endcase
		if (!ref_pulse_subsystem_enable) begin
			gate = 1'b0;
		end
	end

	// Per-output retiming and weights
	always_comb begin
		next_rt = 3'h0;
		next_w = 21'h000000;
		for (int i = 0; i < 3; i++) begin
			next_rt[i] = ref_pulse_subsystem_enable &&
				pick_clk(phase_sel[i], interp_inphase_clock, interp_quadrature_clock);
			next_w[i*7 +: 7] = inphase_w[i];
		end
		next_pulse = {3{gate}};
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_pulse_out <= 3'h0;
			retimer_clk_out <= 3'h0;
			delay_weights <= 21'h000000;
			delay_gen_bypass <= 1'b0;
		end else begin
			ref_pulse_out <= next_pulse;
			retimer_clk_out <= next_rt;
			delay_weights <= next_w;
			delay_gen_bypass <= ~ref_pulse_subsystem_enable | reg_ctrl[1];
		end
	end

	chk_disabled_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		!ref_pulse_subsystem_enable |=> ref_pulse_out == 3'h0)
		else $error("pulse output while subsystem disabled");
	chk_burst_ends_low: assert property (@(posedge mclk) disable iff (sys_rst)
		state == SRG_IDLE && ref_pulse_source_mode == MODE_BURST && !burst_req
		|=> ref_pulse_out == 3'h0)
		else $error("burst output high after count exhausted");
	chk_cont_follows_div: assert property (@(posedge mclk) disable iff (sys_rst)
		ref_pulse_subsystem_enable && ref_pulse_source_mode == MODE_CONT
		|=> ref_pulse_out[0] == $past(div_out))
		else $error("continuous output does not follow divider");
	chk_burst_load: assert property (@(posedge mclk) disable iff (sys_rst)
		ref_pulse_subsystem_enable && ref_pulse_source_mode == MODE_BURST && burst_req
		&& burst_pulse_count != '0 |=> left == $past(burst_pulse_count))
		else $error("burst count not loaded");

	// Armed sequencer handing over to the burst
	sequence srg_arm_to_burst;
		state == SRG_RUN ##1 state == SRG_BURST;
	endsequence
	chk_burst_full_first: assert property (@(posedge mclk) disable iff (sys_rst)
		srg_arm_to_burst |-> div_out)
		else $error("burst did not start on a period boundary");
	// Final divider period of a burst with no new request
	sequence srg_last_period;
		state == SRG_BURST && left == CNT_W'(1) && period_end && !burst_req;
	endsequence
	chk_burst_stops: assert property (@(posedge mclk) disable iff (sys_rst)
		srg_last_period |=> state == SRG_IDLE)
		else $error("burst ran past its count");
	chk_retimer_off: assert property (@(posedge mclk) disable iff (sys_rst)
		!ref_pulse_subsystem_enable |=> retimer_clk_out == 3'h0)
		else $error("retimer clock while subsystem disabled");
endmodule : srg_top

// *** verification/srg_conv_model.sv ***
`timescale 1ns/1ps
// Converter side: tallies timing pulses on lane 0, flags skew across the three lanes
module srg_conv_model (
	input wire logic mclk,
	input wire logic clr,
	input wire logic [2:0] pulse_in,
	output logic [7:0] n_pulse,
	output logic [7:0] n_high,
	output logic lane_skew
);
	logic prev;
	// Prev keeps tracking during clear, so a window count is exact
	always_ff @(posedge mclk) begin
		prev <= pulse_in[0];
		if (clr) begin
			n_pulse <= 8'h00;
			n_high <= 8'h00;
			lane_skew <= 1'b0;
		end else begin
			if (pulse_in[0] && !prev)
				n_pulse <= n_pulse + 8'h01;
			if (pulse_in[0])
				n_high <= n_high + 8'h01;
			if (pulse_in != {3{pulse_in[0]}})
				lane_skew <= 1'b1;
		end
	end
endmodule : srg_conv_model

// *** verification/tb_sysref_generator_config.sv ***
`timescale 1ns/1ps
module tb_sysref_generator_config import srg_pkg::*;;
	logic mclk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0;
	logic burst_req = 1'b0, ext_req = 1'b0, ick = 1'b0, qck = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [2:0] pulse, rclk;
	logic [20:0] wts;
	logic byp, skew;
	logic [7:0] n_pulse, n_high;
	logic [1:0] p;
	int failures = 0, n_compared = 0, cyc = 0;
	srg_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .burst_req(burst_req), .ext_req(ext_req),
		.interp_inphase_clock(ick), .interp_quadrature_clock(qck), .ref_pulse_out(pulse),
		.retimer_clk_out(rclk), .delay_weights(wts), .delay_gen_bypass(byp));
	srg_conv_model conv_u (.mclk(mclk), .clr(clr), .pulse_in(pulse), .n_pulse(n_pulse),
		.n_high(n_high), .lane_skew(skew));
	// 125 MHz clock
	always #4 mclk = ~mclk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data is only valid in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk("rdata", rdata, exp);
	endtask : rchk
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cycles
	// Counted burst; high time per pulse is half the ratio in predivided ticks
	task automatic burst(input logic [3:0] cnt, input logic [11:0] n, input logic [1:0] pre);
		int pd;
		pd = (pre == PRE_DIV4) ? 4 : (pre == PRE_DIV2) ? 2 : 1;
		wr_reg(OFS_CTRL, {11'h000, 1'b1, 2'h0, pre});
		wr_reg(OFS_BURST_DIV, {cnt, n});
		wr_reg(OFS_MODE_OUT0, 16'h07F1);
		cycles(8);
		@(posedge mclk);
		clr <= 1'b1;
		burst_req <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		burst_req <= 1'b0;
		// One extra period covers the wait for the divider boundary
		cycles((int'(cnt) + 1) * int'(n) * pd + 20);
		chk("burst pulses", n_pulse, 32'(cnt));
		chk("burst high", n_high, 32'(cnt) * 32'(n / 2) * pd);
		chk("lane skew", skew, 1'b0);
	endtask : burst
	task automatic print_verdict;
		$display("checks %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		cycles(8);
		sys_rst <= 1'b0;
		chk("pulse rst", pulse, 3'h0);
		rchk(OFS_BURST_DIV, 16'h1003);
		chk("weights rst", wts, {3{7'h7F}});
		rchk(OFS_MODE_OUT0, 16'h07F0);
		rchk(OFS_OUT1_Q0, 16'hFE00);
		rchk(OFS_OUT2_Q1, 16'hFE00);
		rchk(8'h20, 16'h0000);
		// Weight pair of output 0 moved together, sum kept at 0x7F
		wr_reg(OFS_MODE_OUT0, 16'hFBF0);
		wr_reg(OFS_OUT1_Q0, 16'hFE40);
		rchk(OFS_MODE_OUT0, 16'h03F0);
		rchk(OFS_OUT1_Q0, 16'hFE40);
		chk("weights", wts, {7'h7F, 7'h7F, 7'h3F});
		wr_reg(OFS_MODE_OUT0, 16'h07F0);
		wr_reg(OFS_OUT1_Q0, 16'hFE00);
		// Continuous, ratio 4: 10 pulses, 20 high cycles in 40
		wr_reg(OFS_CTRL, 16'h0010);
		wr_reg(OFS_BURST_DIV, 16'h1004);
		cycles(8);
		chk("bypass", byp, 1'b0);
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		cycles(40);
		chk("cont pulses", n_pulse, 10);
		chk("cont high", n_high, 20);
		burst(4'h3, 12'h004, PRE_DIV1);
		burst(4'hF, 12'h002, PRE_DIV1);
		burst(4'h2, 12'h002, PRE_DIV2);
		// Odd ratio only with delay generators bypassed (ctrl bit1)
		burst(4'h1, 12'h005, PRE_DIV4);
		chk("bypass", byp, 1'b1);
		// Repeater follows the request; mode 3 stays low
		wr_reg(OFS_MODE_OUT0, 16'h07F2);
		ext_req <= 1'b1;
		cycles(3);
		chk("repeat", pulse, 3'h7);
		wr_reg(OFS_MODE_OUT0, 16'h07F3);
		cycles(3);
		chk("mode3", pulse, 3'h0);
		ext_req <= 1'b0;
		// Every phase code against two I/Q combinations
		for (int k = 0; k < 8; k++) begin
			p = k[1:0];
			ick <= k[2];
			qck <= ~k[2];
			wr_reg(OFS_MODE_OUT0, {5'h00, 7'h7F, p, 2'h0});
			wr_reg(OFS_OUT1_Q0, {7'h7F, p, 7'h00});
			wr_reg(OFS_OUT2_Q1, {7'h7F, p, 7'h00});
			cycles(4);
			chk("retimer", rclk, {3{p == PH_INTERP_INPHASE_CLOCK_N ? ~k[2] : p == PH_INTERP_QUADRATURE_CLOCK_N ? k[2] :
				p == PH_INTERP_QUADRATURE_CLOCK ? ~k[2] : k[2]}});
		end
		// Subsystem off silences pulses and retimer clocks; bypass goes high
		wr_reg(OFS_MODE_OUT0, 16'h07F2);
		ext_req <= 1'b1;
		wr_reg(OFS_CTRL, 16'h0000);
		cycles(4);
		chk("off pulse", pulse, 3'h0);
		chk("off retimer", rclk, 3'h0);
		chk("off bypass", byp, 1'b1);
		// Control keeps only its defined bits; idle status reads zero
		wr_reg(OFS_CTRL, 16'hFFEF);
		rchk(OFS_CTRL, 16'h0003);
		rchk(OFS_STATUS, 16'h0000);
		print_verdict();
	end
endmodule : tb_sysref_generator_config
